// ==== black_cal_config_regs.sv ====
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Summary of operation
// - Bypass bit clear adds digital offset to output; set passes samples uncorrected.
// - Mode field picks black only, white full search, white fine; 11 reserved.
// - Line count 1..254 runs that many lines, 255 forever, 0 reserved.
// - Digital step scaling: single LSB, one half, one quarter, one eighth.
// - Analog step scaling: error divided by 16 at 00, then a further half, quarter, eighth.
// - Black pixels averaged per line: 4, 8, 16 or 32.
// - Black target on 11-bit scale, times 32 on 16-bit scale; reset 64.
// - Registers other than page select reachable only while page select at index 1F holds 2.
module black_cal_config_regs
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [6:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [6:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire black_cal_pkg::pix_t pix_in,
  input wire logic cal_start,
  output black_cal_pkg::pix_t front_end_output,
  output black_cal_pkg::cal_cfg_t cal_cfg,
  output logic cal_active,
  output logic signed [black_cal_pkg::DOFS_W-1:0] digital_offset_corrector,
  output logic signed [black_cal_pkg::AOFS_W-1:0] analog_offset_corrector
);
  import black_cal_pkg::*;

  logic [7:0] ctrl_q, lines_q, bcfg_q, tgt_q;
  logic [3:0] page_q;
  logic aw_held_q, w_held_q, w_lane_q, avg_ok_q, do_write, wr_ok, rd_ok;
  logic [4:0] aw_idx_q, ar_idx;
  logic [7:0] w_byte_q;
  logic [31:0] rd_word;
  cal_state_t state_q;
  logic [7:0] done_lines_q;
  logic [5:0] pix_cnt_q;
  logic [20:0] sum_q;
  logic [15:0] avg_q;
  logic [5:0] npix;
  logic signed [17:0] err, dstep, astep, dsum, asum, corr;

  // Register index decode, gated by the page select
  function automatic logic mapped(input logic [4:0] idx, input logic [3:0] pg);
    logic hit;
    hit = (idx == IDX_PAGE);
    if (pg == CAL_PAGE)
      hit = hit || idx == IDX_CTRL || idx == IDX_LINES || idx == IDX_BCFG
            || idx == IDX_TGT || idx == IDX_STAT;
    return hit;
  endfunction

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_ok = mapped(aw_idx_q, page_q) && aw_idx_q != IDX_STAT;
  assign ar_idx = s_axi_araddr[6:2];
  assign rd_ok = mapped(ar_idx, page_q);

  // Address and data may arrive in either order; each is held until both exist
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_idx_q <= 5'h00;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[6:2];
      end
      else if (do_write)
        aw_held_q <= 1'b0;
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid
                       && s_axi_awvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_held_q <= 1'b0;
      s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid
                      && s_axi_wvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Only byte lane 0 carries register data; bits above read as zero except in the status word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RST;
      lines_q <= LINES_RST;
      bcfg_q <= BCFG_RST;
      tgt_q <= TGT_RST;
      page_q <= PAGE_RST;
    end
    else if (do_write && wr_ok && w_lane_q)
    begin
      unique case (aw_idx_q)
        IDX_PAGE: page_q <= w_byte_q[3:0];
        IDX_CTRL: ctrl_q <= {5'h00, w_byte_q[2:0]};
        IDX_LINES: lines_q <= w_byte_q;
        IDX_BCFG: bcfg_q <= {2'b00, w_byte_q[5:0]};
        IDX_TGT: tgt_q <= w_byte_q;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (ar_idx)
      IDX_PAGE: rd_word[3:0] = page_q;
      IDX_CTRL: rd_word[7:0] = ctrl_q;
      IDX_LINES: rd_word[7:0] = lines_q;
      IDX_BCFG: rd_word[7:0] = bcfg_q;
      IDX_TGT: rd_word[7:0] = tgt_q;
      IDX_STAT: rd_word = {6'h00, analog_offset_corrector, done_lines_q,
                           digital_offset_corrector[6:0], cal_active};
      default: ;
    endcase
    if (!rd_ok)
      rd_word = 32'h0000_0000;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  assign cal_cfg = '{mode: cal_mode_t'(ctrl_q[MODE_LSB+:2]),
                     digital_offset_bypass: ctrl_q[BYPASS_BIT],
                     lines: lines_q,
                     digital_offset_step_scale: bcfg_q[DSCALE_LSB+:2],
                     analog_offset_step_scale: bcfg_q[ASCALE_LSB+:2],
                     black_pixels: bcfg_q[NPIX_LSB+:2],
                     target: tgt_q};

  // Reserved mode or reserved line count never starts a run
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      done_lines_q <= 8'h00;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (cal_start && cal_cfg.mode != CAL_RESERVED
              && lines_q != LINES_RESERVED)
          begin
            state_q <= ST_RUN;
            done_lines_q <= 8'h00;
          end
        ST_RUN:
          if (pix_in.valid && pix_in.line_end)
          begin
            if (lines_q != LINES_INFINITE)
              done_lines_q <= done_lines_q + 8'h01;
            if (lines_q != LINES_INFINITE && done_lines_q + 8'h01 >= lines_q)
              state_q <= ST_IDLE;
          end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cal_active <= 1'b0;
    else
      cal_active <= state_q == ST_RUN;
  end

  // Black pixel averaging over a power-of-two window
  assign npix = 6'(1 << (NPIX_BASE_LOG2 + int'(cal_cfg.black_pixels)));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pix_cnt_q <= 6'h00;
      sum_q <= 21'h000000;
      avg_q <= 16'h0000;
      avg_ok_q <= 1'b0;
    end
    else if (pix_in.valid && pix_in.line_end)
    begin
      pix_cnt_q <= 6'h00;
      sum_q <= 21'h000000;
      avg_ok_q <= 1'b0;
    end
    else if (pix_in.valid && pix_in.black && pix_cnt_q < npix)
    begin
      pix_cnt_q <= pix_cnt_q + 6'h01;
      sum_q <= sum_q + 21'(pix_in.data);
      if (pix_cnt_q + 6'h01 == npix)
      begin
        avg_q <= 16'((sum_q + 21'(pix_in.data)) >>
                 (NPIX_BASE_LOG2 + int'(cal_cfg.black_pixels)));
        avg_ok_q <= 1'b1;
      end
    end
  end

  assign err = 18'($signed({2'b00, 16'(tgt_q) << TARGET_SHIFT}))
               - $signed({2'b00, avg_q});

  // Digital step scale 00 moves one LSB for any nonzero error; other scales shift the error right
  always_comb
  begin
    if (cal_cfg.digital_offset_step_scale == 2'b00)
      dstep = (err > 0) ? 18'sd1 : (err < 0) ? -18'sd1 : 18'sd0;
    else
      dstep = err >>> cal_cfg.digital_offset_step_scale;
    astep = err >>> (ANA_SHIFT + int'(cal_cfg.analog_offset_step_scale));
  end

  assign dsum = 18'(digital_offset_corrector) + dstep;
  assign asum = 18'(analog_offset_corrector) + astep;

  // Loops saturate at their range ends rather than wrapping
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      digital_offset_corrector <= '0;
      analog_offset_corrector <= '0;
    end
    else if (state_q == ST_RUN && pix_in.valid && pix_in.line_end && avg_ok_q)
    begin
      if (dsum > $signed((DOFS_W+2)'({1'b0, {(DOFS_W-1){1'b1}}})))
        digital_offset_corrector <= {1'b0, {(DOFS_W-1){1'b1}}};
      else if (dsum < -$signed((DOFS_W+2)'({1'b1, {(DOFS_W-1){1'b0}}})))
        digital_offset_corrector <= {1'b1, {(DOFS_W-1){1'b0}}};
      else
        digital_offset_corrector <= DOFS_W'(dsum);
      if (asum > $signed((AOFS_W+2)'({1'b0, {(AOFS_W-1){1'b1}}})))
        analog_offset_corrector <= {1'b0, {(AOFS_W-1){1'b1}}};
      else if (asum < -$signed((AOFS_W+2)'({1'b1, {(AOFS_W-1){1'b0}}})))
        analog_offset_corrector <= {1'b1, {(AOFS_W-1){1'b0}}};
      else
        analog_offset_corrector <= AOFS_W'(asum);
    end
  end

  assign corr = $signed({2'b00, pix_in.data}) + 18'(digital_offset_corrector);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      front_end_output <= '0;
    else
    begin
      front_end_output.valid <= pix_in.valid;
      front_end_output.black <= pix_in.black;
      front_end_output.line_end <= pix_in.line_end;
      if (cal_cfg.digital_offset_bypass)
        front_end_output.data <= pix_in.data;
      else if (corr < 0)
        front_end_output.data <= 16'h0000;
      else if (corr > 18'sh0ffff)
        front_end_output.data <= 16'hffff;
      else
        front_end_output.data <= corr[15:0];
    end
  end
endmodule // black_cal_config_regs

// ==== black_cal_pkg.sv ====
package black_cal_pkg;
  // Printed offsets are register indexes; byte address is four times the index
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_LINES = 5'h01;
  localparam logic [4:0] IDX_BCFG = 5'h02;
  localparam logic [4:0] IDX_TGT = 5'h03;
  localparam logic [4:0] IDX_STAT = 5'h1e;
  localparam logic [4:0] IDX_PAGE = 5'h1f;
  localparam logic [3:0] CAL_PAGE = 4'h2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LINES_RST = 8'h00;
  localparam logic [7:0] BCFG_RST = 8'h14;
  localparam logic [7:0] TGT_RST = 8'h40;
  localparam logic [3:0] PAGE_RST = 4'h0;
  localparam int BYPASS_BIT = 2;
  localparam int MODE_LSB = 0;
  localparam int DSCALE_LSB = 4;
  localparam int ASCALE_LSB = 2;
  localparam int NPIX_LSB = 0;
  localparam logic [7:0] LINES_INFINITE = 8'hff;
  localparam logic [7:0] LINES_RESERVED = 8'h00;
  localparam int TARGET_SHIFT = 5;
  localparam int NPIX_BASE_LOG2 = 2;
  localparam int ANA_SHIFT = 4;
  localparam int DOFS_W = 12;
  localparam int AOFS_W = 10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CAL_BLACK_ONLY,
    CAL_WHITE_FULL,
    CAL_WHITE_FINE,
    CAL_RESERVED
  } cal_mode_t;

  typedef enum logic {ST_IDLE, ST_RUN} cal_state_t;

  typedef struct packed {
    cal_mode_t mode;
    logic digital_offset_bypass;
    logic [7:0] lines;
    logic [1:0] digital_offset_step_scale;
    logic [1:0] analog_offset_step_scale;
    logic [1:0] black_pixels;
    logic [7:0] target;
  } cal_cfg_t;

  typedef struct packed {
    logic valid;
    logic black;
    logic line_end;
    logic [15:0] data;
  } pix_t;
endpackage

// ==== black_cal_config_regs_monitor.sv ====
`timescale 1ns/10ps
module black_cal_config_regs_monitor
  import black_cal_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire black_cal_pkg::pix_t pix_in,
  input wire logic cal_start,
  input wire black_cal_pkg::pix_t front_end_output,
  input wire black_cal_pkg::cal_cfg_t cal_cfg,
  input wire logic cal_active,
  input wire logic signed [black_cal_pkg::DOFS_W-1:0] digital_offset_corrector,
  input wire logic signed [black_cal_pkg::AOFS_W-1:0] analog_offset_corrector
);
  logic signed [17:0] sum_c;
  logic [15:0] exp_c;
  logic line_c;
  assign sum_c = $signed({2'b00, pix_in.data}) + 18'(digital_offset_corrector);
  assign exp_c = sum_c < 0 ? 16'h0000 : (sum_c > 18'sh0ffff ? 16'hffff : sum_c[15:0]);
  assign line_c = pix_in.valid && pix_in.line_end;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_output_corr:
    assert property ($past(pix_in.valid) |-> front_end_output.data ==
      ($past(cal_cfg.digital_offset_bypass) ? $past(pix_in.data) : $past(exp_c)))
    else $error("output data wrong");
  chk_pix_delay:
    assert property (front_end_output.valid == $past(pix_in.valid))
    else $error("output valid wrong");
  chk_start_run:
    assert property (cal_start && !cal_active && cal_cfg.mode != CAL_RESERVED &&
      cal_cfg.lines != 8'h00 |-> ##[1:2] cal_active)
    else $error("run did not start");
  chk_start_refused:
    assert property (cal_start && !cal_active && !$past(cal_start) &&
      (cal_cfg.mode == CAL_RESERVED || cal_cfg.lines == 8'h00) |-> ##2 !cal_active)
    else $error("reserved setting started a run");
  chk_endless_run:
    assert property (cal_active && cal_cfg.lines == LINES_INFINITE |=> cal_active)
    else $error("endless run stopped");
  chk_stop_on_line:
    assert property ($fell(cal_active) |-> $past(line_c, 2) || $past(line_c, 3))
    else $error("run ended without a line");
  chk_offsets_idle:
    assert property (!cal_active && !$past(cal_active) && !$past(cal_start) |=>
      $stable(digital_offset_corrector) && $stable(analog_offset_corrector))
    else $error("offset moved while idle");
  chk_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  cover property (cal_active ##1 !cal_active);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
  cover property (front_end_output.valid && cal_cfg.digital_offset_bypass);
endmodule // black_cal_config_regs_monitor

bind black_cal_config_regs black_cal_config_regs_monitor i_black_cal_config_regs_monitor (
  .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .pix_in, .cal_start,
  .front_end_output, .cal_cfg, .cal_active, .digital_offset_corrector, .analog_offset_corrector);

// ==== black_cal_config_regs_tb.sv ====
`timescale 1ns/10ps
module black_cal_config_regs_tb;
  import black_cal_pkg::*;
  typedef struct {logic [6:0] a; logic [31:0] w; logic [7:0] e; logic [1:0] r;} row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, cal_start, cal_active;
  logic [6:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  pix_t pix_in, front_end_output;
  cal_cfg_t cal_cfg;
  logic signed [DOFS_W-1:0] digital_offset_corrector;
  logic signed [AOFS_W-1:0] analog_offset_corrector;
  int fails, checked;
  logic [7:0] rst_v [4] = '{8'h00, 8'h00, 8'h14, 8'h40};
  row_t rows [6] = '{'{7'h00, 32'hff, 8'h07, RESP_OKAY}, '{7'h00, 32'h05, 8'h05, RESP_OKAY},
    '{7'h04, 32'h1a5, 8'ha5, RESP_OKAY}, '{7'h08, 32'hff, 8'h3f, RESP_OKAY},
    '{7'h08, 32'h1b, 8'h1b, RESP_OKAY}, '{7'h10, 32'h55, 8'h00, RESP_SLVERR}};

  black_cal_config_regs i_black_cal_config_regs (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pix_in, .cal_start,
    .front_end_output, .cal_cfg, .cal_active, .digital_offset_corrector,
    .analog_offset_corrector);

  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Each channel released only at the edge that takes it
  task automatic wr(logic [6:0] a, logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rchk(logic [6:0] a, logic [7:0] e, logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rdata", rdv, {24'h0, e});
    chk("rresp", 32'(s_axi_rresp), 32'(r));
  endtask

  task automatic start();
    @(posedge aclk);
    cal_start <= 1'b1;
    @(posedge aclk);
    cal_start <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  // Lines of four black pixels at level zero, closed by a non-black line end
  task automatic feed(int n);
    repeat (n)
      for (int i = 0; i < 5; i++)
      begin
        @(posedge aclk);
        pix_in <= '{1'b1, i < 4, i == 4, 16'h0000};
      end
    @(posedge aclk);
    pix_in <= '0;
  endtask

  task automatic px(logic [15:0] d, logic [15:0] e);
    @(posedge aclk);
    pix_in <= '{1'b1, 1'b0, 1'b0, d};
    @(posedge aclk);
    pix_in <= '0;
    @(posedge aclk);
    chk("out", 32'(front_end_output.data), 32'(e));
    chk("outf", 32'({front_end_output.valid, front_end_output.black,
      front_end_output.line_end}), 32'h4);
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    fails++;
    end_of_test();
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cal_start, pix_in} <= '0;
    s_axi_wstrb <= 4'hf;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(7'h08, 8'h00, RESP_SLVERR);
    wr(7'h7c, 32'h2);
    for (int i = 0; i < 4; i++) rchk(7'(4 * i), rst_v[i], RESP_OKAY);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      wr(rows[i].a, rows[i].w);
      chk("bresp", 32'(resp), 32'(rows[i].r));
      rchk(rows[i].a, rows[i].e, rows[i].r);
    end
    chk("cfg", 32'(cal_cfg), 32'(25'h0e9_5b40));
    wr(7'h7c, 32'h1);
    wr(7'h08, 32'h00);
    chk("page", 32'(resp), 32'(RESP_SLVERR));
    wr(7'h7c, 32'h2);
    rchk(7'h08, 8'h1b, RESP_OKAY);
    wr(7'h78, 32'h1);
    chk("ro", 32'(resp), 32'(RESP_SLVERR));
    $display("test regs done");
    wr(7'h00, 32'h0);
    wr(7'h04, 32'h3);
    wr(7'h08, 32'h0);
    wr(7'h0c, 32'h40);
    start();
    chk("active", 32'(cal_active), 32'h1);
    feed(3);
    repeat (3) @(posedge aclk);
    chk("active", 32'(cal_active), 32'h0);
    chk("dofs", 32'(digital_offset_corrector), 32'd3);
    chk("aofs", 32'(analog_offset_corrector), 32'd384);
    px(16'h0100, 16'h0103);
    px(16'hfffe, 16'hffff);
    wr(7'h00, 32'h4);
    px(16'h0100, 16'h0100);
    $display("test cal done");
    for (int i = 0; i < 2; i++)
    begin
      wr(7'h00, i ? 32'h0 : 32'h3);
      wr(7'h04, i ? 32'h0 : 32'h3);
      start();
      chk("active", 32'(cal_active), 32'h0);
    end
    wr(7'h04, 32'hff);
    start();
    feed(3);
    chk("active", 32'(cal_active), 32'h1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("active", 32'(cal_active), 32'h0);
    rchk(7'h7c, 8'h00, RESP_OKAY);
    $display("test reserved done");
    end_of_test();
  end
endmodule // black_cal_config_regs_tb
